// ===== pwos_pkg.sv
/*
 * Shared constants and types of the pressure window, offset and status
 * register bank: byte offsets, field positions, reset values and the
 * carrier structs of the register access port.
 * Assumes a serial front end that turns host frames into single-cycle
 * byte read and write strobes on ref_clk.
 */
package pwos_pkg;

   // =====================================================================
   // Register byte offsets
   // =====================================================================
   localparam logic [7:0] PWOS_ADDR_UPPER_LO  = 8'h46;   // Upper threshold [7:0]
   localparam logic [7:0] PWOS_ADDR_UPPER_HI  = 8'h47;   // Upper threshold [15:8]
   localparam logic [7:0] PWOS_ADDR_LOWER_LO  = 8'h48;   // Lower threshold [7:0]
   localparam logic [7:0] PWOS_ADDR_LOWER_HI  = 8'h49;   // Lower threshold [15:8]
   localparam logic [7:0] PWOS_ADDR_OFFSET_LO = 8'h4C;   // User offset [7:0]
   localparam logic [7:0] PWOS_ADDR_OFFSET_HI = 8'h4D;   // User offset [15:8]
   localparam logic [7:0] PWOS_ADDR_STATUS    = 8'h60;   // Processing status

   // =====================================================================
   // Status register fields and reset values
   // =====================================================================
   localparam int         PWOS_BIT_SELFTEST_INCOMPLETE_FLAG = 3;       // Self-test incomplete
   localparam int         PWOS_BIT_SELFTEST_ACTIVE_FLAG  = 2;       // Self-test active
   localparam int         PWOS_BIT_CM_ERR     = 1;       // Common-mode error
   localparam int         PWOS_BIT_ST_ERR     = 0;       // Self-test error
   localparam logic [7:0] PWOS_RST_BYTE       = 8'h00;   // Threshold/offset bytes
   localparam logic [7:0] PWOS_RST_STATUS     = 8'h08;   // Status after reset
   localparam logic [15:0] PWOS_THR_OFF       = 16'h0000; // Threshold disabled code
   localparam logic [7:0] PWOS_RD_UNMAPPED    = 8'h00;   // Read of unmapped byte

   // =====================================================================
   // Carrier types
   // =====================================================================
   typedef struct packed {
      logic       wr;      // One-cycle write strobe
      logic       rd;      // One-cycle read strobe
      logic [7:0] addr;    // Byte address
      logic [7:0] wdata;   // Write data
   } pwos_req_t;

   typedef struct packed {
      logic       valid;   // One-cycle read answer
      logic [7:0] rdata;   // Read data
   } pwos_rsp_t;

   typedef struct packed {
      logic       valid;   // One-cycle new calibrated sample
      logic [15:0] value;  // Calibrated pressure, unsigned
   } pwos_sample_t;

   typedef struct packed {
      logic [3:0] selftest_control_bits;   // Self-test control bits
      logic       cm_fault;  // Front-end common mode out of limits (level)
      logic       st_fail;   // Internal self-test failed (pulse)
      logic       tx_cm_rep; // Sensor transmission reported the error (pulse)
   } pwos_evt_t;

endpackage

// ===== pwos_regbank.sv
/*
 * Pressure window comparator thresholds, signed user offset and processing
 * status register bank, with parity error detection over the writable bytes.
 * Assumes: a serial front end that delivers one-cycle byte strobes, the
 * calibrated pressure as one-cycle samples, and the interrupt polarity and
 * stretch selection from the interrupt configuration register outside.
 */
//
// Behaviour
// - Threshold/offset writes ignored once init locked
// - Threshold/offset bytes covered by parity detection
// - Upper and lower thresholds independent unsigned 16-bit
// - Thresholds at 46h-49h, low byte first, reset zero
// - Zero threshold disables only its own comparison
// - Both thresholds zero keeps interrupt off
// - Offset-changing write resets pressure processing path
// - Signed offset added to calibrated pressure
// - Offset at 4Ch/4Dh, reset zero, read/write
// - Status at 60h, bits 7-4 read zero
// - Incomplete flag set at reset, cleared by self-test
// - Active flag equals OR of self-test controls
// - Common-mode error set on front-end excursion
// - Common-mode error cleared by read or transmission
// - Self-test error set on failure, reset-only clear
// - Polarity selects outside or inside window
// - No stretch: pin follows latest sample condition
`timescale 1ns/1ps

module pwos_regbank (
   input  wire logic                ref_clk,
   input  wire logic                nrst,
   input  wire pwos_pkg::pwos_req_t req,
   input  wire logic                end_of_init_lock,
   input  wire logic                interrupt_polarity,
   input  wire logic [1:0]          interrupt_stretch_select,
   input  wire pwos_pkg::pwos_sample_t sample,
   input  wire pwos_pkg::pwos_evt_t evt,
   output pwos_pkg::pwos_rsp_t      rsp,
   output logic                     int_pin,
   output logic                     path_reset,
   output logic [15:0]              reported_pressure,
   output logic                     array_error
);
   import pwos_pkg::*;

   // =====================================================================
   // State
   // =====================================================================
   typedef struct packed {
      logic [15:0] upper;      // Upper threshold
      logic [15:0] lower;      // Lower threshold
      logic [15:0] offset;     // Signed user offset
      logic [5:0]  parity;     // One parity bit per writable byte
      logic        selftest_incomplete_flag; // Self-test not yet run
      logic        cm_err;     // Common-mode error, sticky
      logic        st_err;     // Self-test error, sticky
      logic        irq;        // Interrupt pin
      logic        path_rst;   // Processing path reset pulse
      logic [15:0] pressure;   // Reported pressure
      logic        arr_err;    // Register array error, sticky
      pwos_rsp_t   rsp;        // Read answer
   } pwos_state_t;

   localparam pwos_state_t PWOS_STATE_RST = '{
      upper:      {PWOS_RST_BYTE, PWOS_RST_BYTE},
      lower:      {PWOS_RST_BYTE, PWOS_RST_BYTE},
      offset:     {PWOS_RST_BYTE, PWOS_RST_BYTE},
      parity:     6'h00,
      selftest_incomplete_flag: PWOS_RST_STATUS[PWOS_BIT_SELFTEST_INCOMPLETE_FLAG],
      cm_err:     PWOS_RST_STATUS[PWOS_BIT_CM_ERR],
      st_err:     PWOS_RST_STATUS[PWOS_BIT_ST_ERR],
      irq:        1'b0,
      path_rst:   1'b0,
      pressure:   16'h0000,
      arr_err:    1'b0,
      rsp:        '{valid: 1'b0, rdata: PWOS_RD_UNMAPPED}
   };

   pwos_state_t st;              // Registered state
   pwos_state_t next_st;         // Next state

   // =====================================================================
   // Combinational helpers
   // =====================================================================
   logic        wr_ok;           // Write accepted (not locked)
   logic        selftest_active_flag;       // Any self-test control bit set
   logic        stat_read;       // Read of the status byte
   logic [15:0] adj;             // Sample plus user offset
   logic        upper_en;        // Upper threshold in use
   logic        lower_en;        // Lower threshold in use
   logic        in_window;       // Adjusted sample inside the window
   logic        cond;            // Interrupt condition of this sample
   logic [7:0]  status_byte;     // Assembled status byte
   logic [47:0] bytes;           // Writable bytes, low to high offset

   assign wr_ok     = req.wr && !end_of_init_lock;
   assign selftest_active_flag = |evt.selftest_control_bits;
   assign stat_read = req.rd && (req.addr == PWOS_ADDR_STATUS);
   assign adj       = sample.value + st.offset;
   assign upper_en  = (st.upper != PWOS_THR_OFF);
   assign lower_en  = (st.lower != PWOS_THR_OFF);
   // Each bound only constrains when its threshold is in use
   assign in_window = (!upper_en || (adj <= st.upper))
                   && (!lower_en || (adj >= st.lower));
   // Polarity picks inside or outside; no threshold means no interrupt
   assign cond      = (upper_en || lower_en)
                   && (interrupt_polarity ? in_window : !in_window);
   assign bytes     = {st.offset, st.lower, st.upper};

   always_comb begin
      status_byte = 8'h00;
      status_byte[PWOS_BIT_SELFTEST_INCOMPLETE_FLAG] = st.selftest_incomplete_flag;
      status_byte[PWOS_BIT_SELFTEST_ACTIVE_FLAG]  = selftest_active_flag;
      status_byte[PWOS_BIT_CM_ERR]     = st.cm_err;
      status_byte[PWOS_BIT_ST_ERR]     = st.st_err;
   end

   // =====================================================================
   // Next-state logic
   // =====================================================================
   always_comb begin
      next_st = st;
      next_st.path_rst  = 1'b0;
      next_st.rsp.valid = 1'b0;

      // Byte writes, ignored while locked
      if (wr_ok) begin
         unique case (req.addr)
            PWOS_ADDR_UPPER_LO: begin
               next_st.upper[7:0] = req.wdata;
               next_st.parity[0]  = ^req.wdata;
            end
            PWOS_ADDR_UPPER_HI: begin
               next_st.upper[15:8] = req.wdata;
               next_st.parity[1]   = ^req.wdata;
            end
            PWOS_ADDR_LOWER_LO: begin
               next_st.lower[7:0] = req.wdata;
               next_st.parity[2]  = ^req.wdata;
            end
            PWOS_ADDR_LOWER_HI: begin
               next_st.lower[15:8] = req.wdata;
               next_st.parity[3]   = ^req.wdata;
            end
            PWOS_ADDR_OFFSET_LO: begin
               next_st.offset[7:0] = req.wdata;
               next_st.parity[4]   = ^req.wdata;
               next_st.path_rst    = (req.wdata != st.offset[7:0]);
            end
            PWOS_ADDR_OFFSET_HI: begin
               next_st.offset[15:8] = req.wdata;
               next_st.parity[5]    = ^req.wdata;
               next_st.path_rst     = (req.wdata != st.offset[15:8]);
            end
            default: begin
               // Other addresses belong to other blocks
            end
         endcase
      end

      // Parity check over every stored byte; error is sticky
      for (int i = 0; i < 6; i++) begin
         if ((^bytes[i*8 +: 8]) != st.parity[i]) begin
            next_st.arr_err = 1'b1;
         end
      end

      // Byte reads, answered one cycle later
      if (req.rd) begin
         next_st.rsp.valid = 1'b1;
         unique case (req.addr)
            PWOS_ADDR_UPPER_LO:  next_st.rsp.rdata = st.upper[7:0];
            PWOS_ADDR_UPPER_HI:  next_st.rsp.rdata = st.upper[15:8];
            PWOS_ADDR_LOWER_LO:  next_st.rsp.rdata = st.lower[7:0];
            PWOS_ADDR_LOWER_HI:  next_st.rsp.rdata = st.lower[15:8];
            PWOS_ADDR_OFFSET_LO: next_st.rsp.rdata = st.offset[7:0];
            PWOS_ADDR_OFFSET_HI: next_st.rsp.rdata = st.offset[15:8];
            PWOS_ADDR_STATUS:    next_st.rsp.rdata = status_byte;
            default:             next_st.rsp.rdata = PWOS_RD_UNMAPPED;
         endcase
      end

      // Self-test incomplete clears once any self-test is enabled
      if (selftest_active_flag) begin
         next_st.selftest_incomplete_flag = 1'b0;
      end

      // Common-mode error: clear on read or report, set wins
      if (stat_read || evt.tx_cm_rep) begin
         next_st.cm_err = 1'b0;
      end
      if (evt.cm_fault) begin
         next_st.cm_err = 1'b1;
      end

      // Self-test error only leaves through reset
      if (evt.st_fail) begin
         next_st.st_err = 1'b1;
      end

      // New sample: report it and re-evaluate the pin
      if (sample.valid) begin
         next_st.pressure = adj;
         next_st.irq      = cond;
      end
   end

   // =====================================================================
   // State register
   // =====================================================================
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         st <= PWOS_STATE_RST;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign rsp               = st.rsp;
   assign int_pin           = st.irq;
   assign path_reset        = st.path_rst;
   assign reported_pressure = st.pressure;
   assign array_error       = st.arr_err;

   // =====================================================================
   // Assertions
   // =====================================================================
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   // Locked writes leave every threshold and offset byte alone
   AST_LOCKED_WRITE: assert property (
      (req.wr && end_of_init_lock) |=> ($stable(st.upper) && $stable(st.lower)
                                        && $stable(st.offset)))
      else $error("Locked write changed a threshold or offset");

   AST_UPPER_LO_WRITE: assert property (
      (wr_ok && req.addr == PWOS_ADDR_UPPER_LO)
         |=> (st.upper[7:0] == $past(req.wdata)) && $stable(st.lower))
      else $error("Upper threshold low byte not written");

   // A parity error stays until reset
   AST_PARITY_STICKY: assert property (
      array_error |=> array_error)
      else $error("Array error flag dropped");

   // No threshold in use means the pin never rises
   AST_BOTH_OFF: assert property (
      (sample.valid && !upper_en && !lower_en) |=> !int_pin)
      else $error("Interrupt raised with both thresholds off");

   AST_OFFSET_RESET: assert property (
      (wr_ok && req.addr == PWOS_ADDR_OFFSET_LO && req.wdata != st.offset[7:0])
         |=> path_reset ##1 !path_reset)
      else $error("Offset change did not pulse path reset");

   // Reported value is the sample plus the signed offset, wrapped
   AST_SUM: assert property (
      sample.valid |=> reported_pressure == 16'($past(sample.value) + $past(st.offset)))
      else $error("Reported pressure is not sample plus offset");

   AST_STATUS_READ: assert property (
      stat_read |=> rsp.valid && (rsp.rdata[7:4] == 4'h0)
                    && (rsp.rdata[PWOS_BIT_SELFTEST_ACTIVE_FLAG] == $past(selftest_active_flag)))
      else $error("Status read returned wrong reserved or active bits");

   AST_INCOMPLETE: assert property (
      selftest_active_flag |=> !st.selftest_incomplete_flag [*2])
      else $error("Self-test incomplete not cleared");

   AST_CM_SET: assert property (
      evt.cm_fault |=> st.cm_err)
      else $error("Common-mode error not set");

   AST_CM_CLEAR: assert property (
      (stat_read && !evt.cm_fault) |=> !st.cm_err)
      else $error("Common-mode error not cleared by read");

   AST_ST_ERR: assert property (
      st.st_err |=> st.st_err)
      else $error("Self-test error cleared without reset");

   // Each sample decides the pin one cycle later
   AST_PIN_FOLLOWS: assert property (
      sample.valid |=> (int_pin == $past(cond)))
      else $error("Interrupt pin does not follow latest sample");

   // Between samples the pin keeps the last verdict
   AST_PIN_HOLD: assert property (
      !sample.valid |=> $stable(int_pin))
      else $error("Interrupt pin moved without a new sample");

   // Lower bound alone still raises the pin below it
   AST_LOWER_ONLY: assert property (
      (sample.valid && !upper_en && lower_en && !interrupt_polarity
       && (adj < st.lower)) |=> int_pin)
      else $error("Lower threshold ignored with upper threshold off");

   // Writing one threshold leaves the other untouched
   AST_LOWER_HI_WRITE: assert property (
      (wr_ok && req.addr == PWOS_ADDR_LOWER_HI)
         |=> (st.lower[15:8] == $past(req.wdata)) && $stable(st.upper))
      else $error("Lower threshold high byte not written alone");

   // Offset high byte reads back what is stored
   AST_OFFSET_HI_READ: assert property (
      (req.rd && req.addr == PWOS_ADDR_OFFSET_HI)
         |=> rsp.valid && (rsp.rdata == $past(st.offset[15:8])))
      else $error("Offset high byte read back wrong");

   // Path reset only ever follows a write to an offset byte
   AST_PATH_RST_SRC: assert property (
      path_reset |-> $past(wr_ok) && (($past(req.addr) == PWOS_ADDR_OFFSET_LO)
                                      || ($past(req.addr) == PWOS_ADDR_OFFSET_HI)))
      else $error("Path reset without an offset write");

   // Incomplete flag holds until a self-test is enabled
   AST_INCMPLT_HOLD: assert property (
      (st.selftest_incomplete_flag && !selftest_active_flag) |=> st.selftest_incomplete_flag)
      else $error("Self-test incomplete cleared without a self-test");

   // A failed self-test sets the error flag
   AST_ST_ERR_SET: assert property (
      evt.st_fail |=> st.st_err)
      else $error("Self-test error not set on failure");

   // A transmission that carried the error clears it
   AST_TX_CLEAR: assert property (
      (evt.tx_cm_rep && !evt.cm_fault) |=> !st.cm_err)
      else $error("Common-mode error not cleared by transmission");

   // =====================================================================
   // Cover points of the main scenarios
   // =====================================================================
   COV_INT_RAISED:   cover property (sample.valid && cond ##1 int_pin);
   COV_ONE_SIDED:    cover property (sample.valid && !upper_en && lower_en ##1 int_pin);
   COV_OFFSET_RESET: cover property (path_reset);
   COV_CM_READ:      cover property (st.cm_err && stat_read ##1 !st.cm_err);
   COV_LOCKED:       cover property (req.wr && end_of_init_lock);

endmodule

// ===== pwos_host_model.sv
/*
 * Host controller model for the pressure window, offset and status bank:
 * byte write and byte read transfers over the register access port.
 * Assumes callers enter each task just after a rising edge of ref_clk.
 */
`timescale 1ns/1ps

module pwos_host_model (
   input  wire logic                ref_clk,
   output pwos_pkg::pwos_req_t      req,
   input  wire pwos_pkg::pwos_rsp_t rsp
);
   import pwos_pkg::*;

   // =====================================================================
   // Idle bus at start
   // =====================================================================
   initial begin
      req = '0;
   end

   // Byte write: strobe for one edge, then address and data are scrambled
   task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      @(posedge ref_clk);
   endtask

   // Byte read: answer is sampled in the cycle after the taking edge
   // The host never requests sensor result bytes here
   task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'hA5};
      @(posedge ref_clk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'h5A};
      #1;
      v = rsp.valid;
      d = rsp.rdata;
      @(posedge ref_clk);
   endtask
endmodule

// ===== tb.sv
/*
 * Self-checking testbench of the pressure window, offset and status bank.
 * Assumes the host model above and the register bank with its own checks.
 */
`timescale 1ns/1ps

module tb;
   import pwos_pkg::*;

   // =====================================================================
   // Signals and bookkeeping
   // =====================================================================
   logic         ref_clk;                 // 50 MHz clock
   logic         nrst;                    // Synchronous reset, active low
   logic         lock;                    // Init lock level
   logic         pol;                     // Interrupt polarity
   pwos_req_t    req;                     // Host requests
   pwos_rsp_t    rsp;                     // Read answers
   pwos_sample_t sample;                  // Calibrated samples
   pwos_evt_t    evt;                     // Status events
   logic         int_pin;                 // Interrupt output
   logic         path_reset;              // Processing path reset pulse
   logic         array_error;             // Parity error flag
   logic [15:0]  reported_pressure;       // Offset-added pressure
   int           fails;                   // Mismatch count
   int           compares;                // Comparison count
   int           pr_cnt;                  // Path reset cycles seen
   int           exp_pr;                  // Path reset pulses expected
   logic [7:0]   shadow [8'h46:8'h4D];    // Expected register bytes
   logic [15:0]  smp [0:4] = '{16'h07F0, 16'h07EF, 16'h0FF0, 16'h0FF1, 16'h0000};

   pwos_host_model u_pwos_host_model (.ref_clk(ref_clk), .req(req), .rsp(rsp));

   pwos_regbank u_pwos_regbank (
      .ref_clk(ref_clk), .nrst(nrst), .req(req), .end_of_init_lock(lock),
      .interrupt_polarity(pol), .interrupt_stretch_select(2'b00), .sample(sample),
      .evt(evt), .rsp(rsp), .int_pin(int_pin), .path_reset(path_reset),
      .reported_pressure(reported_pressure), .array_error(array_error)
   );

   // Clock generator
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // Count every cycle with the path reset high, so a long pulse shows up
   always @(posedge ref_clk) begin
      if (path_reset === 1'b1) pr_cnt++;
   end

   // =====================================================================
   // Helpers
   // =====================================================================
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      u_pwos_host_model.read_byte(a, d, v);
      check("read_valid", {15'h0000, v}, 16'h0001);
      check("read_data", {8'h00, d}, {8'h00, exp});
   endtask

   // Write with the expected effect kept in the shadow bytes
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if (!lock && (a inside {[8'h46:8'h49], 8'h4C, 8'h4D})) begin
         if (a >= 8'h4C && shadow[a] !== d) exp_pr++;
         shadow[a] = d;
      end
      u_pwos_host_model.write_byte(a, d);
   endtask

   // Read back every byte 46h..4Dh (4Ah/4Bh unmapped, zero)
   task automatic check_regs();
      for (int a = 8'h46; a <= 8'h4D; a++) begin
         rd_chk(a[7:0], shadow[a]);
      end
      check("path_reset_count", pr_cnt[15:0], exp_pr[15:0]);
      check("array_error", {15'h0000, array_error}, 16'h0000);
   endtask

   function automatic logic exp_int(input logic [15:0] v);
      logic [15:0] up;
      logic [15:0] lo;
      logic [15:0] adj;
      logic        in_win;
      up = {shadow[8'h47], shadow[8'h46]};
      lo = {shadow[8'h49], shadow[8'h48]};
      adj = v + {shadow[8'h4D], shadow[8'h4C]};
      in_win = (up == 16'h0000 || adj <= up) && (lo == 16'h0000 || adj >= lo);
      if (up == 16'h0000 && lo == 16'h0000) return 1'b0;
      return pol ? in_win : !in_win;
   endfunction

   // One sample; interrupt and result are looked at in the next cycle
   task automatic send(input logic [15:0] v);
      logic        ei;
      logic [15:0] er;
      ei = exp_int(v);
      er = v + {shadow[8'h4D], shadow[8'h4C]};
      sample <= '{valid: 1'b1, value: v};
      @(posedge ref_clk);
      sample <= '{valid: 1'b0, value: ~v};
      #1;
      check("int_pin", {15'h0000, int_pin}, {15'h0000, ei});
      check("reported_pressure", reported_pressure, er);
      @(posedge ref_clk);
   endtask

   task automatic pulse(input logic cm, input logic fail, input logic tx);
      evt.cm_fault <= cm;
      evt.st_fail <= fail;
      evt.tx_cm_rep <= tx;
      @(posedge ref_clk);
      evt.cm_fault <= 1'b0;
      evt.st_fail <= 1'b0;
      evt.tx_cm_rep <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic print_verdict();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      print_verdict();
   end

   // =====================================================================
   // Main sequence
   // =====================================================================
   initial begin
      nrst = 1'b0;
      lock = 1'b0;
      pol = 1'b0;
      sample = '0;
      evt = '0;
      fails = 0;
      compares = 0;
      pr_cnt = 0;
      exp_pr = 0;
      for (int a = 8'h46; a <= 8'h4D; a++) shadow[a] = 8'h00;
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      check_regs();
      rd_chk(8'h60, 8'h08);
      wr(8'h4A, 8'h55);
      wr(8'h60, 8'hFF);
      rd_chk(8'h60, 8'h08);
      // Window 0800h..1000h, small positive offset kept clear of the rails
      wr(8'h46, 8'h00);
      wr(8'h47, 8'h10);
      wr(8'h48, 8'h00);
      wr(8'h49, 8'h08);
      wr(8'h4C, 8'h10);
      wr(8'h4D, 8'h00);
      check_regs();
      for (int p = 0; p < 2; p++) begin
         pol <= p[0];
         @(posedge ref_clk);
         foreach (smp[i]) send(smp[i]);
      end
      // Negative offset, both bytes change
      pol <= 1'b0;
      wr(8'h4C, 8'hF0);
      wr(8'h4D, 8'hFF);
      send(16'h0805);
      send(16'h1008);
      // Upper threshold off, lower still compares
      wr(8'h46, 8'h00);
      wr(8'h47, 8'h00);
      send(16'hFFE0);
      send(16'h0700);
      // Both off: interrupt stays low even for inside polarity
      wr(8'h48, 8'h00);
      wr(8'h49, 8'h00);
      pol <= 1'b1;
      send(16'h0900);
      send(16'h0100);
      check_regs();
      // Locked writes are dropped
      lock <= 1'b1;
      @(posedge ref_clk);
      wr(8'h4C, 8'h33);
      wr(8'h46, 8'h77);
      check_regs();
      // Each self-test control bit alone
      for (int i = 0; i < 4; i++) begin
         evt.selftest_control_bits <= 4'h1 << i;
         @(posedge ref_clk);
         rd_chk(8'h60, 8'h04);
      end
      evt.selftest_control_bits <= 4'h0;
      @(posedge ref_clk);
      rd_chk(8'h60, 8'h00);
      pulse(1'b1, 1'b0, 1'b0);
      rd_chk(8'h60, 8'h02);
      rd_chk(8'h60, 8'h00);
      pulse(1'b1, 1'b0, 1'b0);
      pulse(1'b0, 1'b0, 1'b1);
      rd_chk(8'h60, 8'h00);
      pulse(1'b0, 1'b1, 1'b0);
      rd_chk(8'h60, 8'h01);
      rd_chk(8'h60, 8'h01);
      // Second reset in mid-run
      nrst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      rd_chk(8'h60, 8'h08);
      rd_chk(8'h4D, 8'h00);
      check("int_after_reset", {15'h0000, int_pin}, 16'h0000);
      print_verdict();
   end
endmodule
